/* File: hw/can_core_params.svh */
`ifndef CAN_CORE_PARAMS_SVH
`define CAN_CORE_PARAMS_SVH
// Contract
// R01 - CAN logic runs from the core clock, no separate clock source
// R02 - Time quantum is one core clock period times the prescaler count
// R03 - Prescaler count is extension register plus one; extension resets to zero
// R04 - Each bit has four segments; their sum is the bit time
// R05 - Every segment is whole quanta; the edge segment is one quantum
// R06 - Software picks a delay segment covering the round-trip propagation delay
// R07 - Software splits phase buffers equally, post-sample one more if odd
// R08 - Software keeps the post-sample buffer at least two quanta
// R09 - Software sets jump width to min of four and pre-sample buffer
// R10 - Jump width and both segment fields are stored minus one
// R11 - Bit timing packs after at 0x1000, before 0x0100, jump 0x0040, prescaler 1
// R12 - Software selects the CAN page and sets hold and change enable first
// R13 - Software loads index 0x03 then writes high and low data bytes
// R14 - Writing an object number to command request moves a whole object
// R15 - Two independent interface sets reach any of 32 message objects
// R16 - Objects carry direction and arbitration identifier for acceptance filtering
// R17 - Message handler flag registers are read only
// R18 - Only control, status and test are direct; all are reachable indexed
// R19 - Indexed access uses an index pointer and high and low data bytes
// R20 - Index advances by one after low byte access inside interface ranges
// R21 - Bit timing writes take effect only while change enable is set
// R22 - Indexed space is 128 sixteen-bit words
// R23 - Indexed write commits on low byte write with the latched high byte
// R24 - Direct and indexed control, status and test share one storage

// Direct register selects on the host port
`define CAN_PAGE 8'h01
`define SFR_CONTROL 8'hf8
`define SFR_TEST 8'hdb
`define SFR_STATUS 8'hc0
`define SFR_INDEX 8'hda
`define SFR_DATH 8'hd9
`define SFR_DATL 8'hd8

// Indexed register numbers
`define IDX_CONTROL 7'h00
`define IDX_STATUS 7'h01
`define IDX_ERROR 7'h02
`define IDX_BIT_TIMING 7'h03
`define IDX_INTERRUPT 7'h04
`define IDX_TEST 7'h05
`define IDX_PRESC_EXT 7'h06
`define IDX_SET1_FIRST 7'h08
`define IDX_SET1_LAST 7'h12
`define IDX_SET2_FIRST 7'h20
`define IDX_SET2_LAST 7'h2a
`define IDX_TXRQ_LO 7'h40
`define IDX_TXRQ_HI 7'h41
`define IDX_NEWDAT_LO 7'h48
`define IDX_NEWDAT_HI 7'h49
`define IDX_INTPND_LO 7'h50
`define IDX_INTPND_HI 7'h51
`define IDX_VALID_LO 7'h58
`define IDX_VALID_HI 7'h59

// Reset values
`define RST_CONTROL 16'h0001
`define RST_BIT_TIMING 16'h2301
`define RST_CMD_REQ 16'h0001
`define RST_MASK 16'hffff

// Field positions
`define CTRL_INIT 0
`define CTRL_CHG_EN 6
`define CTRL_TEST 7
`define TEST_RX 7
`define BT_AFTER_LSB 12
`define BT_BEFORE_LSB 8
`define BT_JUMP_LSB 6
`define CMDMASK_WR 7
`define IF_WORDS 11
`define OBJ_WORDS 9
`define OBJ_ARB2 3
`define OBJ_MSGCTRL 4
`define ARB2_VALID 15
`define MC_NEWDAT 15
`define MC_INTPND 13
`define MC_TXRQ 8

`endif

/* File: hw/can_core_pkg.sv */
`default_nettype none
package can_core_pkg;
  typedef logic [15:0] word_t;
  typedef logic [7:0] byte_t;
  // Bit segment sequencer states
  typedef enum logic [1:0] {SEG_SYNC, SEG_BEFORE, SEG_AFTER} seg_state_e;
endpackage : can_core_pkg
`default_nettype wire

/* File: hw/can_msg_ram.sv */
`timescale 1ns/1ps
`default_nettype none
`include "can_core_params.svh"
module can_msg_ram #(
  parameter int N_OBJ = 32,
  parameter int OBJ_W = 144
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_wr_en,
  input wire logic [4:0] i_addr,
  input wire logic [OBJ_W-1:0] i_wr_obj,
  output logic [OBJ_W-1:0] o_rd_obj,
  output logic [N_OBJ-1:0] o_valid_flags,
  output logic [N_OBJ-1:0] o_txrq_flags,
  output logic [N_OBJ-1:0] o_newdat_flags,
  output logic [N_OBJ-1:0] o_intpnd_flags
);
  import can_core_pkg::*;

  logic [OBJ_W-1:0] mem_q [N_OBJ];

  // Object store, cleared so all objects start invalid
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      for (int i = 0; i < N_OBJ; i++)
        mem_q[i] <= '0;
    end
    else if (i_wr_en)
    begin
      mem_q[i_addr] <= i_wr_obj;
    end
  end

  assign o_rd_obj = mem_q[i_addr];

  // Handler flags pulled from each object's arbitration and control words
  always_comb
  begin
    for (int i = 0; i < N_OBJ; i++)
    begin
      o_valid_flags[i] = mem_q[i][`OBJ_ARB2*16 + `ARB2_VALID]; // R16
      o_txrq_flags[i] = mem_q[i][`OBJ_MSGCTRL*16 + `MC_TXRQ];
      o_newdat_flags[i] = mem_q[i][`OBJ_MSGCTRL*16 + `MC_NEWDAT];
      o_intpnd_flags[i] = mem_q[i][`OBJ_MSGCTRL*16 + `MC_INTPND];
    end
  end
endmodule : can_msg_ram
`default_nettype wire

/* File: hw/can_bit_timing_and_reg_access.sv */
`timescale 1ns/1ps
`default_nettype none
`include "can_core_params.svh"
module can_bit_timing_and_reg_access #(
  parameter int N_OBJ = 32
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_sfr_page,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_can_rx,
  output var can_core_pkg::byte_t o_sfr_rdata,
  output var can_core_pkg::word_t o_bit_timing,
  output logic o_tq_tick,
  output logic o_sample_point,
  output logic o_bit_start
);
  import can_core_pkg::*;

  localparam int OBJ_W = `OBJ_WORDS * 16;

  logic [7:0] index_q;
  byte_t hi_latch_q;
  byte_t rdata_q;
  word_t ctrl_q;
  word_t status_q;
  word_t test_q;
  word_t bt_q;
  word_t ext_q;
  word_t if_q [2][`IF_WORDS];
  word_t idx_word;
  word_t test_rd;
  logic page_ok;
  logic wr;
  logic rd;
  logic datl_acc;
  logic commit;
  logic [6:0] commit_idx;
  word_t commit_word;
  logic [1:0] cmt_if;
  logic [3:0] cmt_off;
  logic [1:0] rd_if;
  logic [3:0] rd_off;
  logic [5:0] obj_num;
  logic xfer;
  logic xfer_wr;
  logic [OBJ_W-1:0] ram_wr_obj;
  logic [OBJ_W-1:0] ram_rd_obj;
  logic [N_OBJ-1:0] valid_flags;
  logic [N_OBJ-1:0] txrq_flags;
  logic [N_OBJ-1:0] newdat_flags;
  logic [N_OBJ-1:0] intpnd_flags;
  logic run;
  logic [16:0] presc;
  logic [16:0] pre_q;
  logic tick_w;
  seg_state_e seg_q;
  logic [3:0] seg_cnt_q;
  logic [3:0] before_len;
  logic [3:0] after_len;
  logic tick_q;
  logic sample_q;
  logic start_q;

  // Interface window hit: {hit, set}; set 0 is the first interface
  function automatic logic [1:0] if_hit(input logic [6:0] idx);
    if (idx >= `IDX_SET1_FIRST && idx <= `IDX_SET1_LAST)
      return 2'b10;
    else if (idx >= `IDX_SET2_FIRST && idx <= `IDX_SET2_LAST)
      return 2'b11;
    else
      return 2'b00;
  endfunction : if_hit

  // Word offset inside an interface window
  function automatic logic [3:0] if_off(input logic [6:0] idx);
    logic [6:0] d;
    d = (idx >= `IDX_SET2_FIRST) ? idx - `IDX_SET2_FIRST : idx - `IDX_SET1_FIRST;
    return d[3:0];
  endfunction : if_off

  ////////////////////////////////////////////////////////////////////////////
  // Host access decode
  assign page_ok = (i_sfr_page == `CAN_PAGE);
  assign wr = i_sfr_wr && page_ok;
  assign rd = i_sfr_rd && page_ok;
  assign datl_acc = (wr || rd) && (i_sfr_addr == `SFR_DATL);
  assign commit = wr && (i_sfr_addr == `SFR_DATL); // R23
  assign commit_idx = index_q[6:0]; // R22
  assign commit_word = {hi_latch_q, i_sfr_wdata}; // R23
  assign cmt_if = if_hit(commit_idx);
  assign cmt_off = if_off(commit_idx);
  assign rd_if = cmt_if;
  assign rd_off = cmt_off;

  // Index pointer with autoincrement inside the interface windows
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      index_q <= 8'h00;
    else if (wr && i_sfr_addr == `SFR_INDEX)
      index_q <= i_sfr_wdata; // R19
    else if (datl_acc && cmt_if[1])
      index_q <= index_q + 8'h01; // R20
  end

  // High byte holding stage for indexed writes
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      hi_latch_q <= 8'h00;
    else if (wr && i_sfr_addr == `SFR_DATH)
      hi_latch_q <= i_sfr_wdata; // R19
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol registers, one store for direct and indexed paths
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctrl_q <= `RST_CONTROL;
      status_q <= 16'h0000;
      test_q <= 16'h0000;
    end
    else if (commit)
    begin
      if (commit_idx == `IDX_CONTROL)
        ctrl_q <= commit_word;
      else if (commit_idx == `IDX_STATUS)
        status_q <= commit_word;
      else if (commit_idx == `IDX_TEST)
        test_q <= commit_word;
    end
    else if (wr)
    begin
      if (i_sfr_addr == `SFR_CONTROL)
        ctrl_q[7:0] <= i_sfr_wdata; // R24
      else if (i_sfr_addr == `SFR_STATUS)
        status_q[7:0] <= i_sfr_wdata; // R24
      else if (i_sfr_addr == `SFR_TEST)
        test_q[7:0] <= i_sfr_wdata; // R18
    end
  end

  // Bit timing guarded by change enable, extension guarded by test mode
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      bt_q <= `RST_BIT_TIMING;
      ext_q <= 16'h0000; // R03
    end
    else if (commit)
    begin
      if (commit_idx == `IDX_BIT_TIMING && ctrl_q[`CTRL_CHG_EN])
        bt_q <= commit_word; // R21
      if (commit_idx == `IDX_PRESC_EXT && ctrl_q[`CTRL_TEST])
        ext_q <= commit_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interface sets and message object transfer
  assign obj_num = commit_word[5:0];
  assign xfer = commit && cmt_if[1] && cmt_off == 4'h0
                && obj_num != 6'h00 && obj_num <= 6'd32; // R14
  assign xfer_wr = if_q[cmt_if[0]][1][`CMDMASK_WR];

  // Object image assembled from the mask, arbitration, control and data words
  always_comb
  begin
    ram_wr_obj = '0;
    for (int w = 0; w < `OBJ_WORDS; w++)
      ram_wr_obj[w*16 +: 16] = if_q[cmt_if[0]][w+2];
  end

  // Two independent interface register sets
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      for (int s = 0; s < 2; s++)
      begin
        for (int w = 0; w < `IF_WORDS; w++)
          if_q[s][w] <= (w == 2 || w == 3) ? `RST_MASK : 16'h0000;
        if_q[s][0] <= `RST_CMD_REQ;
      end
    end
    else if (commit && cmt_if[1])
    begin
      if (cmt_off == 4'h0)
        if_q[cmt_if[0]][0] <= {1'b0, commit_word[14:0]}; // R15
      else
        if_q[cmt_if[0]][cmt_off] <= commit_word;
      if (xfer && !xfer_wr)
      begin
        for (int w = 0; w < `OBJ_WORDS; w++)
          if_q[cmt_if[0]][w+2] <= ram_rd_obj[w*16 +: 16]; // R14
      end
    end
  end

  // Message object store shared by both interface sets
  can_msg_ram #(
    .N_OBJ(N_OBJ),
    .OBJ_W(OBJ_W)
  ) u_msg_ram (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_wr_en(xfer && xfer_wr),
    .i_addr(5'(obj_num - 6'h01)),
    .i_wr_obj(ram_wr_obj),
    .o_rd_obj(ram_rd_obj),
    .o_valid_flags(valid_flags),
    .o_txrq_flags(txrq_flags),
    .o_newdat_flags(newdat_flags),
    .o_intpnd_flags(intpnd_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Indexed read word; handler flags have no write path
  assign test_rd = {test_q[15:8], i_can_rx, test_q[6:0]};

  always_comb
  begin
    idx_word = 16'h0000;
    if (commit_idx == `IDX_CONTROL)
      idx_word = ctrl_q;
    else if (commit_idx == `IDX_STATUS)
      idx_word = status_q;
    else if (commit_idx == `IDX_BIT_TIMING)
      idx_word = bt_q;
    else if (commit_idx == `IDX_TEST)
      idx_word = test_rd;
    else if (commit_idx == `IDX_PRESC_EXT)
      idx_word = ext_q;
    else if (rd_if[1])
      idx_word = if_q[rd_if[0]][rd_off];
    else if (commit_idx == `IDX_TXRQ_LO)
      idx_word = txrq_flags[15:0]; // R17
    else if (commit_idx == `IDX_TXRQ_HI)
      idx_word = txrq_flags[31:16];
    else if (commit_idx == `IDX_NEWDAT_LO)
      idx_word = newdat_flags[15:0];
    else if (commit_idx == `IDX_NEWDAT_HI)
      idx_word = newdat_flags[31:16];
    else if (commit_idx == `IDX_INTPND_LO)
      idx_word = intpnd_flags[15:0];
    else if (commit_idx == `IDX_INTPND_HI)
      idx_word = intpnd_flags[31:16];
    else if (commit_idx == `IDX_VALID_LO)
      idx_word = valid_flags[15:0];
    else if (commit_idx == `IDX_VALID_HI)
      idx_word = valid_flags[31:16];
  end

  // Registered read data, one cycle after the read strobe
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      rdata_q <= 8'h00;
    else if (rd)
    begin
      if (i_sfr_addr == `SFR_INDEX)
        rdata_q <= index_q;
      else if (i_sfr_addr == `SFR_DATH)
        rdata_q <= idx_word[15:8]; // R19
      else if (i_sfr_addr == `SFR_DATL)
        rdata_q <= idx_word[7:0];
      else if (i_sfr_addr == `SFR_CONTROL)
        rdata_q <= ctrl_q[7:0]; // R18
      else if (i_sfr_addr == `SFR_STATUS)
        rdata_q <= status_q[7:0];
      else if (i_sfr_addr == `SFR_TEST)
        rdata_q <= test_rd[7:0];
      else
        rdata_q <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quantum prescaler on the core clock, halted while held in init
  assign run = !ctrl_q[`CTRL_INIT];
  assign presc = {1'b0, ext_q} + 17'h00001; // R03
  assign tick_w = run && (pre_q == presc - 17'h00001); // R02
  assign before_len = bt_q[`BT_BEFORE_LSB +: 4]; // R11
  assign after_len = {1'b0, bt_q[`BT_AFTER_LSB +: 3]}; // R11

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      pre_q <= 17'h00000;
    else if (!run || tick_w)
      pre_q <= 17'h00000; // R01
    else
      pre_q <= pre_q + 17'h00001;
  end

  // Bit segment sequencer: edge, before-sample, after-sample
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      seg_q <= SEG_SYNC;
      seg_cnt_q <= 4'h0;
    end
    else if (!run)
    begin
      seg_q <= SEG_SYNC;
      seg_cnt_q <= 4'h0;
    end
    else if (tick_w)
    begin
      case (seg_q)
        SEG_SYNC:
        begin
          seg_q <= SEG_BEFORE; // R05
          seg_cnt_q <= 4'h0;
        end
        SEG_BEFORE:
        begin
          if (seg_cnt_q == before_len)
          begin
            seg_q <= SEG_AFTER; // R10
            seg_cnt_q <= 4'h0;
          end
          else
            seg_cnt_q <= seg_cnt_q + 4'h1;
        end
        default:
        begin
          if (seg_cnt_q == after_len)
          begin
            seg_q <= SEG_SYNC; // R04
            seg_cnt_q <= 4'h0;
          end
          else
            seg_cnt_q <= seg_cnt_q + 4'h1;
        end
      endcase
    end
  end

  // Registered timing strobes
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      tick_q <= 1'b0;
      sample_q <= 1'b0;
      start_q <= 1'b0;
    end
    else
    begin
      tick_q <= tick_w;
      sample_q <= tick_w && seg_q == SEG_BEFORE && seg_cnt_q == before_len;
      start_q <= tick_w && seg_q == SEG_AFTER && seg_cnt_q == after_len;
    end
  end

  assign o_sfr_rdata = rdata_q;
  assign o_bit_timing = bt_q;
  assign o_tq_tick = tick_q;
  assign o_sample_point = sample_q;
  assign o_bit_start = start_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_unit_prescale;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (run && ext_q == 16'h0000 && $past(run) && $past(ext_q) == 16'h0000) |-> tick_w;
  endproperty
  a_unit_prescale: assert property (p_unit_prescale) // R03
    else $error("prescaler of one must tick every cycle");

  property p_bt_locked;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (commit && commit_idx == `IDX_BIT_TIMING && !ctrl_q[`CTRL_CHG_EN]) |=> $stable(bt_q);
  endproperty
  a_bt_locked: assert property (p_bt_locked) // R21
    else $error("bit timing changed without change enable");

  property p_bt_commit;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (commit && commit_idx == `IDX_BIT_TIMING && ctrl_q[`CTRL_CHG_EN])
      |=> bt_q == {$past(hi_latch_q), $past(i_sfr_wdata)};
  endproperty
  a_bt_commit: assert property (p_bt_commit) // R23
    else $error("bit timing did not take latched high and written low byte");

  property p_autoinc;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (datl_acc && cmt_if[1]) |=> index_q == $past(index_q) + 8'h01;
  endproperty
  a_autoinc: assert property (p_autoinc) // R20
    else $error("index did not advance in interface window");

  property p_no_autoinc;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (datl_acc && !cmt_if[1]) |=> $stable(index_q);
  endproperty
  a_no_autoinc: assert property (p_no_autoinc) // R20
    else $error("index moved outside interface window");

  property p_sync_one;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (run && tick_w && seg_q == SEG_SYNC) ##1 run |-> seg_q == SEG_BEFORE;
  endproperty
  a_sync_one: assert property (p_sync_one) // R05
    else $error("edge segment longer than one quantum");

  property p_sample_point;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (tick_w && seg_q == SEG_BEFORE && seg_cnt_q == before_len && run)
      |=> o_sample_point && (seg_q == SEG_AFTER || !run);
  endproperty
  a_sample_point: assert property (p_sample_point) // R10
    else $error("sample point not after before-sample field plus one quanta");

  property p_direct_ctrl;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (wr && i_sfr_addr == `SFR_CONTROL) |=> ctrl_q[7:0] == $past(i_sfr_wdata);
  endproperty
  a_direct_ctrl: assert property (p_direct_ctrl) // R24
    else $error("direct control write not seen in shared store");

  property p_flags_ro;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (commit && commit_idx == `IDX_VALID_LO && !xfer) |=> $stable(valid_flags);
  endproperty
  a_flags_ro: assert property (p_flags_ro) // R17
    else $error("write changed read-only handler flags");
endmodule : can_bit_timing_and_reg_access
`default_nettype wire

/* File: testbench/can_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module can_bus_model (
  input wire logic i_dominant,
  output logic o_rx
);
  ////////////////////////////////////////////////////////////////////////////////
  // Transceiver receive level: recessive high unless another node drives dominant
  assign o_rx = ~i_dominant;
endmodule : can_bus_model
`default_nettype wire

/* File: testbench/can_bit_timing_and_reg_access_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "can_core_params.svh"
module can_bit_timing_and_reg_access_test;
  import can_core_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] page = 8'h01;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic dominant = 1'b0;
  logic can_rx;
  byte_t rdata;
  word_t bit_timing;
  logic tq_tick;
  logic sample_point;
  logic bit_start;
  int mismatches = 0;
  int total_checks = 0;
  int n;
  int delay_q;
  int pre_buf;
  int post_buf;
  int jump;
  word_t w;
  word_t exp_bt;
  byte_t b;
  word_t obj_words [6] = '{16'h0080, 16'hffff, 16'hffff, 16'h1234, 16'h8000, 16'ha100};
  logic [6:0] flag_idx [5] = '{7'h58, 7'h40, 7'h48, 7'h50, 7'h59};
  word_t flag_exp [5] = '{16'h0010, 16'h0010, 16'h0010, 16'h0010, 16'h0000};

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and design
  always #2 ref_clk = ~ref_clk;

  can_bit_timing_and_reg_access dut (
    .i_ref_clk(ref_clk),
    .i_rstn(rstn),
    .i_sfr_page(page),
    .i_sfr_addr(addr),
    .i_sfr_wr(wr),
    .i_sfr_rd(rd),
    .i_sfr_wdata(wdata),
    .i_can_rx(can_rx),
    .o_sfr_rdata(rdata),
    .o_bit_timing(bit_timing),
    .o_tq_tick(tq_tick),
    .o_sample_point(sample_point),
    .o_bit_start(bit_start)
  );

  can_bus_model bus (
    .i_dominant(dominant),
    .o_rx(can_rx)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Host access tasks, driven on the falling edge
  task automatic sfr_wr(input byte_t a, input byte_t d);
    @(negedge ref_clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge ref_clk);
    wr = 1'b0;
  endtask : sfr_wr

  task automatic sfr_rd(input byte_t a, output byte_t d);
    @(negedge ref_clk);
    addr = a;
    rd = 1'b1;
    @(negedge ref_clk);
    rd = 1'b0;
    d = rdata;
  endtask : sfr_rd

  // High byte is latched first, low byte commits the word
  task automatic dat_wr(input word_t v);
    sfr_wr(`SFR_DATH, v[15:8]);
    sfr_wr(`SFR_DATL, v[7:0]);
  endtask : dat_wr

  task automatic idx_wr(input logic [6:0] idx, input word_t v);
    sfr_wr(`SFR_INDEX, {1'b0, idx});
    dat_wr(v);
  endtask : idx_wr

  task automatic idx_rd(input logic [6:0] idx, output word_t v);
    sfr_wr(`SFR_INDEX, {1'b0, idx});
    sfr_rd(`SFR_DATH, v[15:8]);
    sfr_rd(`SFR_DATL, v[7:0]);
  endtask : idx_rd

  ////////////////////////////////////////////////////////////////////////////////
  // Compare tasks
  task automatic check_word(input word_t got, input word_t exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_byte(input byte_t got, input byte_t exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_byte

  // Cycles from a pulse on one timing output to the next pulse on the same or another
  function automatic logic pick(input int s);
    return (s == 0) ? tq_tick : ((s == 1) ? sample_point : bit_start);
  endfunction : pick

  task automatic span(input int a, input int z, output int cyc);
    int k;
    k = 0;
    while (pick(a) !== 1'b1 && k < 2000)
    begin
      @(negedge ref_clk);
      k++;
    end
    cyc = 0;
    do
    begin
      @(negedge ref_clk);
      cyc++;
    end
    while (pick(z) !== 1'b1 && cyc < 2000);
  endtask : span

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hung handshake
  initial
  begin
    #300000;
    mismatches++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    repeat (12) @(negedge ref_clk);
    rstn = 1'b1;
    check_word(bit_timing, 16'h2301);
    sfr_rd(`SFR_CONTROL, b);
    check_byte(b, 8'h01);
    idx_rd(7'h06, w);
    check_word(w, 16'h0000);
    idx_rd(7'h08, w);
    check_word(w, 16'h0001);
    $display("test reset done");

    // Segment plan for a 22 quantum bit
    delay_q = 9;
    pre_buf = 6;
    post_buf = 6;
    jump = (pre_buf < 4) ? pre_buf : 4;
    exp_bt = word_t'((post_buf - 1) * 'h1000 + (delay_q + pre_buf - 1) * 'h100 + (jump - 1) * 'h40);
    check_word(exp_bt, 16'h5ec0);
    idx_wr(7'h03, exp_bt);
    check_word(bit_timing, 16'h2301);
    sfr_wr(`SFR_CONTROL, 8'h41);
    idx_wr(7'h03, exp_bt);
    check_word(bit_timing, exp_bt);
    idx_rd(7'h03, w);
    check_word(w, exp_bt);
    sfr_rd(`SFR_INDEX, b);
    check_byte(b, 8'h03);
    idx_wr(7'h06, 16'h0002);
    idx_rd(7'h06, w);
    check_word(w, 16'h0000);
    $display("test bit timing write done");

    // Run the sequencer with a one clock quantum, then with three
    sfr_wr(`SFR_CONTROL, 8'h40);
    span(2, 2, n);
    check_word(word_t'(n), word_t'(1 + delay_q + pre_buf + post_buf));
    span(1, 2, n);
    check_word(word_t'(n), word_t'(post_buf));
    span(0, 0, n);
    check_word(word_t'(n), 16'h0001);
    sfr_wr(`SFR_CONTROL, 8'hc1);
    idx_wr(7'h06, 16'h0002);
    sfr_wr(`SFR_CONTROL, 8'hc0);
    span(0, 0, n);
    check_word(word_t'(n), 16'h0003);
    span(2, 2, n);
    check_word(word_t'(n), word_t'(3 * (1 + delay_q + pre_buf + post_buf)));
    $display("test quantum and bit length done");

    // Direct and indexed views, refused accesses, bus level
    sfr_wr(`SFR_STATUS, 8'h5a);
    idx_rd(7'h01, w);
    check_word(w, 16'h005a);
    page = 8'h00;
    sfr_wr(`SFR_STATUS, 8'h33);
    page = 8'h01;
    sfr_rd(`SFR_STATUS, b);
    check_byte(b, 8'h5a);
    idx_wr(7'h07, 16'h1234);
    idx_rd(7'h07, w);
    check_word(w, 16'h0000);
    dominant = 1'b1;
    sfr_rd(`SFR_TEST, b);
    check_byte({7'h00, b[7]}, 8'h00);
    dominant = 1'b0;
    sfr_rd(`SFR_TEST, b);
    check_byte({7'h00, b[7]}, 8'h01);
    sfr_wr(`SFR_INDEX, 8'h12);
    sfr_wr(`SFR_DATL, 8'h00);
    sfr_rd(`SFR_INDEX, b);
    check_byte(b, 8'h13);
    sfr_wr(`SFR_INDEX, 8'h2a);
    sfr_rd(`SFR_DATL, b);
    sfr_rd(`SFR_INDEX, b);
    check_byte(b, 8'h2b);
    $display("test register paths done");

    // Object 5 written through set one, read back through set two
    sfr_wr(`SFR_INDEX, 8'h09);
    foreach (obj_words[i])
      dat_wr(obj_words[i]);
    idx_wr(7'h08, 16'h0005);
    foreach (flag_idx[i])
    begin
      idx_rd(flag_idx[i], w);
      check_word(w, flag_exp[i]);
    end
    idx_wr(7'h58, 16'hffff);
    idx_rd(7'h58, w);
    check_word(w, 16'h0010);
    idx_wr(7'h21, 16'h0000);
    idx_wr(7'h20, 16'h0005);
    idx_rd(7'h24, w);
    check_word(w, 16'h1234);
    idx_rd(7'h25, w);
    check_word(w, 16'h8000);
    idx_rd(7'h26, w);
    check_word(w, 16'ha100);
    $display("test message objects done");
    close_out();
  end
endmodule : can_bit_timing_and_reg_access_test
`default_nettype wire
